// ---- pkg/tsc_consts.svh ----
// Register numbers, field positions, reset values and timing counts
// for the tile status/control register bank.
// Assumes inclusion from the package and the bank module only.
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

// Register numbers (status-register index) and resource type byte
`define TSC_REG_FEAT_CTRL        8'h02
`define TSC_REG_BOOT_STAT        8'h03
`define TSC_REG_SEC_CFG          8'h05
`define TSC_REG_OSC_CTRL         8'h06
`define TSC_REG_OSC_TILE_CELL    8'h07
`define TSC_REG_OSC_TILE_WIRE    8'h08
`define TSC_REG_OSC_PERI_CELL    8'h09
`define TSC_REG_OSC_PERI_WIRE    8'h0A
`define TSC_REG_RAM_SIZE         8'h0C
`define TSC_RES_TYPE_BYTE        8'h0B

// Tile feature control fields
`define TSC_FC_TXD_HI            25
`define TSC_FC_TXD_LO            18
`define TSC_FC_DIV_HI            17
`define TSC_FC_DIV_LO            9
`define TSC_FC_RGMII_EN          8
`define TSC_FC_DYN_MODE          5
`define TSC_FC_CLKDIV_EN         4
`define TSC_FC_WMASK             32'h03FF_FF30
`define TSC_FC_RESET             32'h0000_0000

// Boot status fields
`define TSC_BS_PROC_HI           23
`define TSC_BS_PROC_LO           16
`define TSC_BS_OVR_MODE          8
`define TSC_BS_CORE1_OFF         5
`define TSC_BS_NO_OTP_POLL       4
`define TSC_BS_BOOT_RAM          3
`define TSC_BS_BOOT_JTAG         2
`define TSC_BS_PLL_HI            1
`define TSC_BS_PLL_LO            0

// Security configuration fields
`define TSC_SC_WR_DIS            31
`define TSC_SC_NO_GDEBUG         14
`define TSC_SC_LOCK_ALL          12
`define TSC_SC_LOCK_HI           11
`define TSC_SC_LOCK_LO           8
`define TSC_SC_OTP_REDUND        7
`define TSC_SC_OTP_BOOT          5
`define TSC_SC_NO_JTAG_CFG       4
`define TSC_SC_NO_JTAG_TAP       0
`define TSC_SC_WMASK             32'h8000_5FB1

// Oscillator control fields
`define TSC_OC_CORE_EN           1
`define TSC_OC_PERI_EN           0
`define TSC_OC_WMASK             32'h0000_0003

// RAM size reserved bits
`define TSC_RAM_WMASK            32'hFFFF_FFFC

// Oscillator stop settle time: ten core clock cycles
`define TSC_OSC_SETTLE_CYC       10

`endif

// ---- pkg/tsc_pkg.sv ----
// Types for the tile status/control register bank.
// Constants live in tsc_consts.svh.
`default_nettype none
package tsc_pkg;
    `include "tsc_consts.svh"

    typedef enum logic [1:0] {
        TSC_OSC_IDLE   = 2'b00,
        TSC_OSC_RUN    = 2'b01,
        TSC_OSC_SETTLE = 2'b11
    } tsc_osc_state_t;

    typedef logic [15:0] tsc_count_t;
endpackage
`default_nettype wire

// ---- logic/tsc_status_regs.sv ----
// Tile processor status register bank: feature control, boot status,
// security copy, ring oscillator control/counts and RAM size.
// Assumes the core issues one status-register read or write per cycle,
// with a one-cycle strobe, and OTP/strap values stable across reset.
//
// Functional notes
// - TX data delay field, resets zero
// - TX clock high at divider, low half
// - Control bit enables RGMII peripheral ports
// - Control bit enables low-power clock divider
// - Dynamic mode divides only when threads paused
// - Boot status reports 8-bit processor number
// - Boot status reports 2-bit PLL mode
// - Boot status reports boot source flags
// - Security register loaded from OTP copy
// - Top security bit blocks later writes
// - Bits disable global debug and JTAG TAP
// - Lock-all bit and per-sector OTP locks
// - OTP redundancy, OTP boot, JTAG config block
// - Four free-running oscillator counters, started/stopped
// - Core and peripheral oscillator enables reset zero
// - Four read-only 16-bit oscillator counts
// - Oscillator counts survive system reset
// - Oscillators asynchronous, usable as random source
// - Read-only RAM size, low bits zero
`timescale 1ns/100ps
`default_nettype none
`include "tsc_consts.svh"

module tsc_status_regs #(
    parameter logic [31:0] RAM_BYTES = 32'h0008_0000
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    // Status register access from the core
    input  wire logic                ps_wr_i,
    input  wire logic                ps_rd_i,
    input  wire logic [7:0]          ps_num_i,
    input  wire logic [31:0]         ps_wdata_i,
    output logic      [31:0]         ps_rdata_o,
    output logic                     ps_rvalid_o,
    // Straps and OTP copy
    input  wire logic [7:0]          proc_num_i,
    input  wire logic [1:0]          pll_mode_pin_i,
    input  wire logic                boot_ovr_i,
    input  wire logic                core1_off_i,
    input  wire logic                no_otp_poll_i,
    input  wire logic                boot_ram_i,
    input  wire logic                boot_jtag_i,
    input  wire logic [31:0]         otp_sec_i,
    // Thread state
    input  wire logic                all_paused_i,
    // PLL-rate tick and ring oscillator ticks
    input  wire logic                pll_tick_i,
    input  wire logic [3:0]          osc_tick_i,
    // RGMII and clocking controls
    output logic                     rgmii_en_o,
    output logic                     rgmii_txc_o,
    output logic      [7:0]          rgmii_txd_delay_o,
    output logic                     clk_div_active_o,
    // Security controls
    output logic                     gdebug_dis_o,
    output logic                     jtag_tap_dis_o,
    output logic                     otp_lock_all_o,
    output logic      [3:0]          otp_sector_lock_o,
    output logic                     otp_redund_en_o,
    output logic                     otp_boot_force_o,
    output logic                     jtag_cfg_dis_o
);
    import tsc_pkg::*;

    typedef struct packed {
        logic [31:0]    feat;
        logic [31:0]    sec;
        logic [1:0]     osc_en;
        logic           loaded;
        logic [8:0]     div_cnt;
        logic           txc;
        tsc_osc_state_t osc_st;
        logic [3:0]     settle;
        logic [31:0]    rdata;
        logic           rvalid;
        logic           div_active;
    } tsc_state_t;

    tsc_state_t r;
    tsc_state_t next_r;

    // Counters kept apart, no reset
    // Power-up value only; system reset leaves them alone
    tsc_count_t osc_cnt      [4] = '{default: 16'h0000};
    tsc_count_t osc_snap     [4] = '{default: 16'h0000};

    function automatic logic [31:0] tsc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [31:0] mask);
        tsc_merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (r.osc_en[i >= 2 ? 0 : 1] && osc_tick_i[i]) begin
                osc_cnt[i] <= osc_cnt[i] + 16'h0001;
            end
        end
    end

    // Snapshot only once stopped and settled
    always_ff @(posedge clk_i) begin
        if (r.osc_st == TSC_OSC_IDLE) begin
            for (int i = 0; i < 4; i++) begin
                osc_snap[i] <= osc_cnt[i];
            end
        end
    end

    always_comb begin
        logic [31:0] rd;
        logic [8:0]  div;
        rd     = 32'h0000_0000;
        next_r = r;
        div    = r.feat[`TSC_FC_DIV_HI:`TSC_FC_DIV_LO];

        // Load OTP copy first cycle after reset
        if (!r.loaded) begin
            next_r.sec    = otp_sec_i & `TSC_SC_WMASK;
            next_r.loaded = 1'b1;
        end

        if (ps_wr_i) begin
            case (ps_num_i)
                `TSC_REG_FEAT_CTRL: next_r.feat = tsc_merge(r.feat, ps_wdata_i, `TSC_FC_WMASK);
                `TSC_REG_SEC_CFG: begin
                    if (r.loaded && !r.sec[`TSC_SC_WR_DIS]) begin
                        next_r.sec = tsc_merge(r.sec, ps_wdata_i, `TSC_SC_WMASK);
                    end
                end
                `TSC_REG_OSC_CTRL: next_r.osc_en = ps_wdata_i[1:0];
                default: ;
            endcase
        end

        case (ps_num_i)
            `TSC_REG_FEAT_CTRL:     rd = r.feat & `TSC_FC_WMASK;
            `TSC_REG_BOOT_STAT: begin
                rd[`TSC_BS_PROC_HI:`TSC_BS_PROC_LO] = proc_num_i;
                rd[`TSC_BS_OVR_MODE]                = boot_ovr_i;
                rd[`TSC_BS_CORE1_OFF]               = core1_off_i;
                rd[`TSC_BS_NO_OTP_POLL]             = no_otp_poll_i;
                rd[`TSC_BS_BOOT_RAM]                = boot_ram_i;
                rd[`TSC_BS_BOOT_JTAG]               = boot_jtag_i;
                rd[`TSC_BS_PLL_HI:`TSC_BS_PLL_LO]   = pll_mode_pin_i;
            end
            `TSC_REG_SEC_CFG:       rd = r.sec & `TSC_SC_WMASK;
            `TSC_REG_OSC_CTRL:      rd = {30'h0000_0000, r.osc_en};
            `TSC_REG_OSC_TILE_CELL: rd = {16'h0000, osc_snap[0]};
            `TSC_REG_OSC_TILE_WIRE: rd = {16'h0000, osc_snap[1]};
            `TSC_REG_OSC_PERI_CELL: rd = {16'h0000, osc_snap[2]};
            `TSC_REG_OSC_PERI_WIRE: rd = {16'h0000, osc_snap[3]};
            `TSC_REG_RAM_SIZE:      rd = RAM_BYTES & `TSC_RAM_WMASK;
            default:                rd = 32'h0000_0000;
        endcase
        next_r.rdata  = ps_rd_i ? rd : r.rdata;
        next_r.rvalid = ps_rd_i;

        case (r.osc_st)
            TSC_OSC_IDLE: begin
                if (|r.osc_en) begin
                    next_r.osc_st = TSC_OSC_RUN;
                end
            end
            TSC_OSC_RUN: begin
                if (~|r.osc_en) begin
                    next_r.osc_st = TSC_OSC_SETTLE;
                    next_r.settle = 4'h0;
                end
            end
            TSC_OSC_SETTLE: begin
                if (|r.osc_en) begin
                    next_r.osc_st = TSC_OSC_RUN;
                end else if (r.settle == 4'(`TSC_OSC_SETTLE_CYC - 2)) begin
                    next_r.osc_st = TSC_OSC_IDLE;
                end else begin
                    next_r.settle = r.settle + 4'h1;
                end
            end
            default: next_r.osc_st = TSC_OSC_IDLE;
        endcase

        if (pll_tick_i) begin
            next_r.div_cnt = (r.div_cnt >= div) ? 9'h000 : r.div_cnt + 9'h001;
            if (r.div_cnt == div) begin
                next_r.txc = 1'b1;
            end else if (r.div_cnt == (div >> 1)) begin
                next_r.txc = 1'b0;
            end
        end

        next_r.div_active = r.feat[`TSC_FC_CLKDIV_EN] &&
                            (!r.feat[`TSC_FC_DYN_MODE] || all_paused_i);

        if (!rst_b_i) begin
            next_r = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        r <= next_r;
    end

    assign ps_rdata_o        = r.rdata;
    assign ps_rvalid_o       = r.rvalid;
    assign rgmii_en_o        = r.feat[`TSC_FC_RGMII_EN];
    assign rgmii_txc_o       = r.txc;
    assign rgmii_txd_delay_o = r.feat[`TSC_FC_TXD_HI:`TSC_FC_TXD_LO];
    assign clk_div_active_o  = r.div_active;
    assign gdebug_dis_o      = r.sec[`TSC_SC_NO_GDEBUG];
    assign jtag_tap_dis_o    = r.sec[`TSC_SC_NO_JTAG_TAP];
    assign otp_lock_all_o    = r.sec[`TSC_SC_LOCK_ALL];
    assign otp_sector_lock_o = r.sec[`TSC_SC_LOCK_HI:`TSC_SC_LOCK_LO];
    assign otp_redund_en_o   = r.sec[`TSC_SC_OTP_REDUND];
    assign otp_boot_force_o  = r.sec[`TSC_SC_OTP_BOOT];
    assign jtag_cfg_dis_o    = r.sec[`TSC_SC_NO_JTAG_CFG];

endmodule // tsc_status_regs
`default_nettype wire

// ---- verif/tsc_core_model.sv ----
// Core-side model issuing status-register reads and writes.
// Assumes the bench calls acc once per access, never concurrently.
`timescale 1ns/100ps
`default_nettype none
module tsc_core_model (
    // Clock
    input  wire logic        clk_i,
    // Access port
    output logic             ps_wr_o,
    output logic             ps_rd_o,
    output logic [7:0]       ps_num_o,
    output logic [31:0]      ps_wdata_o
);
    initial begin
        ps_wr_o = 1'b0;
        ps_rd_o = 1'b0;
        ps_num_o = 8'h00;
        ps_wdata_o = 32'h0;
    end
    task automatic acc(input logic w, input logic [7:0] n, input logic [31:0] d);
        logic [15:0] rid;
        rid = {n, 8'h0B};
        @(negedge clk_i);
        ps_num_o = rid[15:8];
        ps_wdata_o = d;
        ps_wr_o = w;
        ps_rd_o = ~w;
        @(negedge clk_i);
        ps_wr_o = 1'b0;
        ps_rd_o = 1'b0;
        // Released lines toggle, never trusted
        ps_num_o = ~ps_num_o;
        ps_wdata_o = ~ps_wdata_o;
    endtask
endmodule // tsc_core_model
`default_nettype wire

// ---- verif/tsc_status_regs_asserts.sv ----
// Port checks for the status register bank.
// Assumes a single clock domain; bound to every bank instance.
`timescale 1ns/100ps
`default_nettype none
module tsc_status_regs_chk (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    // Access port
    input wire logic        ps_wr_i,
    input wire logic        ps_rd_i,
    input wire logic [7:0]  ps_num_i,
    input wire logic [31:0] ps_wdata_i,
    input wire logic [31:0] ps_rdata_o,
    input wire logic        ps_rvalid_o,
    // Controls
    input wire logic        pll_tick_i,
    input wire logic        rgmii_en_o,
    input wire logic        rgmii_txc_o,
    input wire logic [7:0]  rgmii_txd_delay_o,
    input wire logic        clk_div_active_o,
    input wire logic [3:0]  otp_sector_lock_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic wr_ctl;
    assign wr_ctl = ps_wr_i && ps_num_i == 8'h02;
    property p_rd_ans; ps_rvalid_o == $past(ps_rd_i); endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer wrong");
    property p_ctl_en; wr_ctl |=> rgmii_en_o == $past(ps_wdata_i[8]); endproperty
    a_ctl_en: assert property (p_ctl_en) else $error("port enable wrong");
    property p_ctl_dly; wr_ctl |=> rgmii_txd_delay_o == $past(ps_wdata_i[25:18]); endproperty
    a_ctl_dly: assert property (p_ctl_dly) else $error("data delay wrong");
    property p_div_off; wr_ctl && !ps_wdata_i[4] |=> ##1 !clk_div_active_o; endproperty
    a_div_off: assert property (p_div_off) else $error("divider not off");
    property p_div_st; wr_ctl && ps_wdata_i[5:4] == 2'b01 |=> ##1 clk_div_active_o; endproperty
    a_div_st: assert property (p_div_st) else $error("static divider off");
    property p_osc_rsv; ps_rd_i && ps_num_i == 8'h06 |=> ps_rdata_o[31:2] == 30'h0; endproperty
    a_osc_rsv: assert property (p_osc_rsv) else $error("control reserved set");
    property p_cnt_rsv;
        ps_rd_i && ps_num_i inside {[8'h07:8'h0A]} |=> ps_rdata_o[31:16] == 16'h0;
    endproperty
    a_cnt_rsv: assert property (p_cnt_rsv) else $error("count reserved set");
    property p_txc; !pll_tick_i && !$past(pll_tick_i) && $past(rst_b_i) |=> $stable(rgmii_txc_o);
    endproperty
    a_txc: assert property (p_txc) else $error("tx clock moved idle");
    property p_lock;
        !(ps_wr_i && ps_num_i == 8'h05) && $past(rst_b_i, 3) |=> $stable(otp_sector_lock_o);
    endproperty
    a_lock: assert property (p_lock) else $error("sector lock moved");
endmodule // tsc_status_regs_chk
bind tsc_status_regs tsc_status_regs_chk tsc_status_regs_chk_inst (.clk_i, .rst_b_i, .ps_wr_i,
    .ps_rd_i, .ps_num_i, .ps_wdata_i, .ps_rdata_o, .ps_rvalid_o, .pll_tick_i, .rgmii_en_o,
    .rgmii_txc_o, .rgmii_txd_delay_o, .clk_div_active_o, .otp_sector_lock_o);
`default_nettype wire

// ---- verif/test_tile_status_control_regs.sv ----
// Self-checking bench for the status register bank.
// Assumes the core model drives accesses and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected %0t mismatch", $time); end end
module test_tile_status_control_regs;
    localparam logic [31:0] RAM = 32'h0001_2347;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        paused = 1'b0;
    logic        tick = 1'b0;
    logic [3:0]  osc = 4'h0;
    logic [15:0] st = 16'h0;
    logic [31:0] v, otp = 32'h0;
    logic [15:0] base [4];
    logic [15:0] cnt [4] = '{default: 16'h0};
    logic [32:0] exp_q [$];
    wire logic   wr, rd, rv, en, txc, cda;
    wire logic [7:0]  num, dly;
    wire logic [9:0]  so;
    wire logic [31:0] wd, rdata;
    int          n_errors = 0;
    int          total_checks = 0;
    int          cyc = 0;
    time         t0;
    tsc_core_model tsc_core_model_inst (.clk_i(clk_i), .ps_wr_o(wr), .ps_rd_o(rd),
        .ps_num_o(num), .ps_wdata_o(wd));
    tsc_status_regs #(.RAM_BYTES(RAM)) tsc_status_regs_inst (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .ps_wr_i(wr), .ps_rd_i(rd), .ps_num_i(num), .ps_wdata_i(wd),
        .ps_rdata_o(rdata), .ps_rvalid_o(rv), .proc_num_i(st[15:8]), .pll_mode_pin_i(st[1:0]),
        .boot_ovr_i(st[7]), .core1_off_i(st[5]), .no_otp_poll_i(st[4]), .boot_ram_i(st[3]),
        .boot_jtag_i(st[2]), .otp_sec_i(otp), .all_paused_i(paused), .pll_tick_i(tick),
        .osc_tick_i(osc), .rgmii_en_o(en), .rgmii_txc_o(txc), .rgmii_txd_delay_o(dly),
        .clk_div_active_o(cda), .gdebug_dis_o(so[9]), .jtag_tap_dis_o(so[8]),
        .otp_lock_all_o(so[7]), .otp_sector_lock_o(so[6:3]), .otp_redund_en_o(so[2]),
        .otp_boot_force_o(so[1]), .jtag_cfg_dis_o(so[0]));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic print_verdict;
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wrt(input logic [7:0] n, input logic [31:0] d);
        tsc_core_model_inst.acc(1'b1, n, d);
    endtask
    task automatic rdq(input logic [7:0] n, input logic [32:0] e);
        exp_q.push_back(e);
        tsc_core_model_inst.acc(1'b0, n, 32'h0);
    endtask
    task automatic do_reset;
        rst_b_i = 1'b0;
        repeat (20) @(negedge clk_i);
        rst_b_i = 1'b1;
        @(negedge clk_i);
    endtask
    // Bit 32 of a note marks a read kept, not compared
    always @(posedge clk_i) begin
        cyc++;
        if (rv === 1'b1 && exp_q.size() == 0) `CHK(1'b1, 1'b0)
        else if (rv === 1'b1 && exp_q[0][32] == 1'b0) `CHK(rdata, exp_q[0][31:0])
        if (rv === 1'b1 && exp_q.size() != 0) void'(exp_q.pop_front());
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        v = $urandom(32'hC3B9_25B9);
        st = 16'($urandom);
        otp = $urandom & 32'h7FFF_FFFF;
        do_reset();
        wrt(8'h03, 32'hFFFF_FFFF);
        wrt(8'h0C, 32'h0);
        rdq(8'h03, {8'h00, st[15:8], 7'h00, st[7], 2'b00, st[5:2], st[1:0]});
        rdq(8'h05, otp & 32'h8000_5FB1);
        `CHK(so, {otp[14], otp[0], otp[12], otp[11:8], otp[7], otp[5], otp[4]})
        rdq(8'h0C, RAM & 32'hFFFF_FFFC);
        rdq(8'h04, 32'h0);
        v = $urandom;
        wrt(8'h02, v);
        `CHK({en, dly}, {v[8], v[25:18]})
        rdq(8'h02, v & 32'h03FF_FF30);
        for (int i = 0; i < 8; i++) begin
            paused = i[1];
            wrt(8'h02, {26'h0, i[0], i[2], 4'h0});
            @(negedge clk_i);
            `CHK(cda, i[2] & (~i[0] | i[1]))
        end
        tick = 1'b1;
        // Ratio four written as three
        wrt(8'h02, 32'h0000_0700);
        @(posedge txc);
        t0 = $time;
        @(posedge txc);
        `CHK($time - t0, 64'd160)
        @(negedge clk_i);
        tick = 1'b0;
        wrt(8'h05, 32'h8000_1010);
        wrt(8'h05, 32'h0000_4001);
        rdq(8'h05, 32'h8000_1010);
        `CHK(so, 10'h081)
        for (int k = 0; k < 4; k++) begin
            rdq(8'h07 + 8'(k), 33'h1_0000_0000);
            base[k] = rdata[15:0];
        end
        wrt(8'h06, 32'hFFFF_FFFF);
        rdq(8'h06, 32'h3);
        repeat (50) begin
            osc = 4'($urandom);
            for (int k = 0; k < 4; k++) cnt[k] += 16'(osc[k]);
            @(negedge clk_i);
        end
        osc = 4'h0;
        rdq(8'h07, {17'h0, base[0]});
        wrt(8'h06, 32'h0);
        // Counts read only once settled
        repeat (10) @(negedge clk_i);
        for (int k = 0; k < 4; k++) rdq(8'h07 + 8'(k), {17'h0, base[k] + cnt[k]});
        do_reset();
        for (int k = 0; k < 4; k++) rdq(8'h07 + 8'(k), {17'h0, base[k] + cnt[k]});
        rdq(8'h06, 32'h0);
        rdq(8'h05, otp & 32'h8000_5FB1);
        repeat (3) @(negedge clk_i);
        `CHK(exp_q.size(), 0)
        print_verdict();
    end
endmodule // test_tile_status_control_regs
`default_nettype wire
